// *** hw/eeprom_autoload_pkg.sv ***
// Shared constants and types for the EEPROM configuration auto-load block.
package eeprom_autoload_pkg;

  // Number of switch ports served by the loader.
  localparam int NUM_PORTS = 4;

  // Width of an EEPROM word address and of an EEPROM data word.
  localparam int ADDR_W = 8;
  localparam int WORD_W = 16;

  // Distance between the EEPROM words of two neighbouring ports.
  localparam logic [7:0] WORD_STEP = 8'h02;

  // EEPROM word addresses of the first port of each group.
  localparam logic [7:0] ADDR_PM_BASE      = 8'h84;  // Ports 2 and 3.
  localparam logic [7:0] ADDR_SLOT_LO_BASE = 8'h92;  // Ports 1 to 3.
  localparam logic [7:0] ADDR_SLOT_HI_BASE = 8'hA2;  // Ports 1 to 3.
  localparam logic [7:0] ADDR_CSR3_LO_BASE = 8'hB0;  // Ports 0 to 3.
  localparam logic [7:0] ADDR_CSR3_HI_BASE = 8'hC0;  // Ports 0 to 3.
  localparam logic [7:0] ADDR_REPLAY_BASE  = 8'hD0;  // Ports 0 to 3.

  // First port number of each group.
  localparam int PM_FIRST_PORT   = 2;
  localparam int SLOT_FIRST_PORT = 1;

  // Field positions inside the EEPROM word.
  localparam int PM_MSB      = 5;   // Power-management control bits.
  localparam int PM_LSB      = 0;
  localparam int RXPOL_BIT   = 6;   // Receive polarity capability disable.
  localparam int VGA_BIT     = 7;   // VGA decode enable.
  localparam int CSR5_MSB    = 15;  // Vendor control word 5 top byte.
  localparam int CSR5_LSB    = 8;
  localparam int REPLAY_MSB  = 12;  // Replay time-out counter.
  localparam int REPLAY_LSB  = 0;
  localparam int TS_MSB      = 14;  // Receive training-sequence count.
  localparam int TS_LSB      = 13;

  // Loaded fields of one port, each named after its register field.
  typedef struct packed {
    logic [5:0]  pmCtrl;              // Offset 74h bits 13:8.
    logic        rxPolarityDisable;   // Offset 74h bit 14.
    logic        vgaDecodeEnable;     // Offset 70h bit 31.
    logic [7:0]  vendorCtrlWord5Top;  // Offset 88h bits 31:24.
    logic [15:0] slotCapLow;          // Offset D4h bits 15:0.
    logic [15:0] slotCapHigh;         // Offset D4h bits 31:16.
    logic [15:0] vendorCtrlWord3Low;  // Offset 80h bits 15:0.
    logic [15:0] vendorCtrlWord3High; // Offset 80h bits 31:16.
    logic [12:0] replayTimeout;       // Offset 70h bits 12:0.
    logic [1:0]  rxTrainingSeqCount;  // Offset 8Ch bits 25:24.
  } port_cfg_s;

  // One EEPROM word as handed over by the EEPROM reader.
  typedef struct packed {
    logic        valid;  // One-cycle strobe for a finished read.
    logic        ok;     // High when the read completed without error.
    logic [7:0]  addr;   // EEPROM word address.
    logic [15:0] data;   // Word contents.
  } eeprom_word_s;

  // Reset defaults of the loaded fields.
  localparam port_cfg_s CFG_RESET = '0;

endpackage

// *** hw/eeprom_port_config_autoload.sv ***
`timescale 1ns/1ns
module eeprom_port_config_autoload (
  input  wire logic                           clk,
  input  wire logic                           sys_rst,
  input  wire eeprom_autoload_pkg::eeprom_word_s eepromWord,
  output      eeprom_autoload_pkg::port_cfg_s
                                              portCfg_q
                                              [eeprom_autoload_pkg::NUM_PORTS]
);

  // Address of a port's word, given the group base and the group index.
  function automatic logic [7:0] wordAddr(input logic [7:0] base,
                                          input int         index);
    logic [7:0] offset;
    offset = 8'(index) * eeprom_autoload_pkg::WORD_STEP;
    return 8'(base + offset);
  endfunction

  // A word is only usable when its read finished without error.
  logic wordTake;  // High for a successfully read word.
  assign wordTake = eepromWord.valid && eepromWord.ok;

  // Every port's fields are updated in one process; each field changes only
  // when its own word arrives, so the rest of the register keeps its value.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      // Defaults stand until the loader has seen the matching words.
      for (int p = 0; p < eeprom_autoload_pkg::NUM_PORTS; p++)
      begin
        portCfg_q[p] <= eeprom_autoload_pkg::CFG_RESET;
      end
    end
    else if (wordTake)
    begin
      for (int p = 0; p < eeprom_autoload_pkg::NUM_PORTS; p++)
      begin
        // Power-management word, ports 2 and 3 only.
        if (p >= eeprom_autoload_pkg::PM_FIRST_PORT &&
            eepromWord.addr == wordAddr(eeprom_autoload_pkg::ADDR_PM_BASE,
                               p - eeprom_autoload_pkg::PM_FIRST_PORT))
        begin
          portCfg_q[p].pmCtrl <= eepromWord.data[
            eeprom_autoload_pkg::PM_MSB:eeprom_autoload_pkg::PM_LSB];
          portCfg_q[p].rxPolarityDisable <=
            eepromWord.data[eeprom_autoload_pkg::RXPOL_BIT];
          portCfg_q[p].vgaDecodeEnable <=
            eepromWord.data[eeprom_autoload_pkg::VGA_BIT];
          portCfg_q[p].vendorCtrlWord5Top <= eepromWord.data[
            eeprom_autoload_pkg::CSR5_MSB:eeprom_autoload_pkg::CSR5_LSB];
        end
        // Slot capability words, ports 1 to 3 only.
        if (p >= eeprom_autoload_pkg::SLOT_FIRST_PORT)
        begin
          if (eepromWord.addr ==
              wordAddr(eeprom_autoload_pkg::ADDR_SLOT_LO_BASE,
                       p - eeprom_autoload_pkg::SLOT_FIRST_PORT))
          begin
            portCfg_q[p].slotCapLow <= eepromWord.data;
          end
          if (eepromWord.addr ==
              wordAddr(eeprom_autoload_pkg::ADDR_SLOT_HI_BASE,
                       p - eeprom_autoload_pkg::SLOT_FIRST_PORT))
          begin
            portCfg_q[p].slotCapHigh <= eepromWord.data;
          end
        end
        // Vendor control word 3 halves, all ports.
        if (eepromWord.addr ==
            wordAddr(eeprom_autoload_pkg::ADDR_CSR3_LO_BASE, p))
        begin
          portCfg_q[p].vendorCtrlWord3Low <= eepromWord.data;
        end
        if (eepromWord.addr ==
            wordAddr(eeprom_autoload_pkg::ADDR_CSR3_HI_BASE, p))
        begin
          portCfg_q[p].vendorCtrlWord3High <= eepromWord.data;
        end
        // Replay time-out and training-sequence count, all ports; D6h
        // is the fourth word of this group and serves port 3.
        if (eepromWord.addr ==
            wordAddr(eeprom_autoload_pkg::ADDR_REPLAY_BASE, p))
        begin
          portCfg_q[p].replayTimeout <= eepromWord.data[
            eeprom_autoload_pkg::REPLAY_MSB:eeprom_autoload_pkg::REPLAY_LSB];
          portCfg_q[p].rxTrainingSeqCount <= eepromWord.data[
            eeprom_autoload_pkg::TS_MSB:eeprom_autoload_pkg::TS_LSB];
        end
      end
    end
  end

  // Checks on the loading, sampled on the core clock.
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // The power-management word of port 2 lands in its pmCtrl field.
  AST_PM_P2_LOAD: assert property (
    wordTake && eepromWord.addr == 8'h84 |=>
      portCfg_q[2].pmCtrl == $past(eepromWord.data[5:0]))
    else $error("Port 2 power control not loaded.");

  AST_RXPOL_P3_LOAD: assert property (
    wordTake && eepromWord.addr == 8'h86 |=>
      portCfg_q[3].rxPolarityDisable == $past(eepromWord.data[6]))
    else $error("Port 3 polarity disable not loaded.");

  AST_VGA_P2_LOAD: assert property (
    wordTake && eepromWord.addr == 8'h84 |=>
      portCfg_q[2].vgaDecodeEnable == $past(eepromWord.data[7]) &&
      portCfg_q[3].vgaDecodeEnable == $past(portCfg_q[3].vgaDecodeEnable))
    else $error("Port 2 VGA enable wrong or port 3 disturbed.");

  AST_CSR5_P3_LOAD: assert property (
    wordTake && eepromWord.addr == 8'h86 |=>
      portCfg_q[3].vendorCtrlWord5Top == $past(eepromWord.data[15:8]))
    else $error("Port 3 vendor word 5 byte not loaded.");

  AST_SLOT_LO_P1_LOAD: assert property (
    wordTake && eepromWord.addr == 8'h92 |=>
      portCfg_q[1].slotCapLow == $past(eepromWord.data) &&
      $stable(portCfg_q[1].slotCapHigh))
    else $error("Port 1 slot capability low half wrong.");

  AST_SLOT_HI_P3_LOAD: assert property (
    wordTake && eepromWord.addr == 8'hA6 |=>
      portCfg_q[3].slotCapHigh == $past(eepromWord.data))
    else $error("Port 3 slot capability high half not loaded.");

  AST_CSR3_LO_P0_LOAD: assert property (
    wordTake && eepromWord.addr == 8'hB0 |=>
      portCfg_q[0].vendorCtrlWord3Low == $past(eepromWord.data))
    else $error("Port 0 vendor word 3 low half not loaded.");

  AST_CSR3_HI_P2_LOAD: assert property (
    wordTake && eepromWord.addr == 8'hC4 |=>
      portCfg_q[2].vendorCtrlWord3High == $past(eepromWord.data))
    else $error("Port 2 vendor word 3 high half not loaded.");

  AST_REPLAY_P1_LOAD: assert property (
    wordTake && eepromWord.addr == 8'hD2 |=>
      portCfg_q[1].replayTimeout == $past(eepromWord.data[12:0]))
    else $error("Port 1 replay time-out not loaded.");

  AST_TS_P0_LOAD: assert property (
    wordTake && eepromWord.addr == 8'hD0 |=>
      portCfg_q[0].rxTrainingSeqCount == $past(eepromWord.data[14:13]))
    else $error("Port 0 training count not loaded.");

  AST_REPLAY_P3_LOAD: assert property (
    wordTake && eepromWord.addr == 8'hD6 |=>
      portCfg_q[3].replayTimeout == $past(eepromWord.data[12:0]) &&
      portCfg_q[3].rxTrainingSeqCount == $past(eepromWord.data[14:13]))
    else $error("Port 3 replay fields not loaded.");

  AST_FAILED_READ_IGNORED: assert property (
    eepromWord.valid && !eepromWord.ok |=> $stable(portCfg_q[0]) &&
      $stable(portCfg_q[1]) && $stable(portCfg_q[2]) &&
      $stable(portCfg_q[3]))
    else $error("A failed read changed a port field.");

  // Main scenarios worth seeing in simulation.
  COV_PM_WORD: cover property (wordTake && eepromWord.addr == 8'h84);
  COV_SLOT_WORD: cover property (wordTake && eepromWord.addr == 8'hA2);
  COV_REPLAY_P3: cover property (wordTake && eepromWord.addr == 8'hD6);
  COV_FAILED_READ: cover property (eepromWord.valid && !eepromWord.ok);

endmodule

// *** tb/eeprom_word_model.sv ***
`timescale 1ns/1ns
// Stands in for the EEPROM reader: hands over one word per strobe.
module eeprom_word_model (
  input  wire logic                          clk,
  output eeprom_autoload_pkg::eeprom_word_s  word
);
  // The bus is quiet with no strobe at time zero.
  initial word = '0;

  // Presents one word just after an edge; the next edge takes it.
  task automatic send(input logic [7:0] a, input logic [15:0] d,
                      input logic good);
    @(posedge clk);
    #1;
    word = '{valid: 1'b1, ok: good, addr: a, data: d};
  endtask

  // Drops the strobe and scrambles the stale fields so nothing lingers.
  task automatic idle();
    @(posedge clk);
    #1;
    word.valid = 1'b0;
    word.ok    = ~word.ok;
    word.addr  = ~word.addr;
    word.data  = ~word.data;
  endtask
endmodule

// *** tb/eeprom_port_config_autoload_tb.sv ***
`timescale 1ns/1ns
// Feeds EEPROM words to the loader and compares every port's fields.
module eeprom_port_config_autoload_tb;
  logic                              clk;      // Core clock.
  logic                              sys_rst;  // Active-high reset.
  eeprom_autoload_pkg::eeprom_word_s word;     // Word from the model.
  eeprom_autoload_pkg::port_cfg_s    cfg [4];  // Loaded fields seen.
  eeprom_autoload_pkg::port_cfg_s    expCfg [4]; // Fields expected.
  int                                error_cnt; // Mismatches found.
  int                                compares;  // Comparisons made.

  // The 4 ns core clock.
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  eeprom_word_model mdl (.clk(clk), .word(word));

  eeprom_port_config_autoload dut (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .eepromWord (word),
    .portCfg_q  (cfg)
  );

  // Works out what a good word does; unmapped slots change nothing.
  task automatic apply(input logic [7:0] a, input logic [15:0] d);
    int p;
    p = int'(a[2:1]);
    if (a[0] || a[3])
      return;
    case (a[7:4])
      4'h8: if (p >= 2)
      begin
        expCfg[p].pmCtrl             = d[5:0];
        expCfg[p].rxPolarityDisable  = d[6];
        expCfg[p].vgaDecodeEnable    = d[7];
        expCfg[p].vendorCtrlWord5Top = d[15:8];
      end
      4'h9: if (p >= 1) expCfg[p].slotCapLow = d;
      4'hA: if (p >= 1) expCfg[p].slotCapHigh = d;
      4'hB: expCfg[p].vendorCtrlWord3Low = d;
      4'hC: expCfg[p].vendorCtrlWord3High = d;
      4'hD:
      begin
        expCfg[p].replayTimeout      = d[12:0];
        expCfg[p].rxTrainingSeqCount = d[14:13];
      end
      default: ;
    endcase
  endtask

  // Compares all four ports against the expectation.
  task automatic checkAll();
    for (int p = 0; p < 4; p++)
    begin
      compares++;
      if (cfg[p] !== expCfg[p])
      begin
        error_cnt++;
        $display("ERROR portCfg_q[%0d] expected %h seen %h",
                 p, expCfg[p], cfg[p]);
      end
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic conclude();
    if (error_cnt == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Sweeps every even slot from 80h to DEh; with gaps set, ok drops on every third.
  task automatic sweep(input logic [15:0] salt, input bit gaps);
    logic [7:0] a;
    logic       good;
    for (int i = 8'h80; i < 8'hE0; i += 2)
    begin
      a = 8'(i);
      good = !gaps || (i % 3 != 0);
      mdl.send(a, {a, ~a} ^ salt, good);
      if (good)
        apply(a, {a, ~a} ^ salt);
      if (!gaps)
      begin
        mdl.idle();
        checkAll();
      end
    end
    mdl.idle();
  endtask

  // Main sequence.
  initial
  begin
    error_cnt = 0;
    compares  = 0;
    sys_rst   = 1'b1;
    for (int p = 0; p < 4; p++)
      expCfg[p] = eeprom_autoload_pkg::CFG_RESET;
    repeat (10) @(posedge clk);
    #1 sys_rst = 1'b0;
    checkAll();
    sweep(16'h0000, 1'b0);
    sweep(16'h5A3C, 1'b1);
    checkAll();
    // Two words to one address back to back: the later one wins.
    mdl.send(8'hD6, 16'h1111, 1'b1);
    mdl.send(8'hD6, 16'h6ABC, 1'b1);
    apply(8'hD6, 16'h6ABC);
    mdl.idle();
    checkAll();
    // A reset in mid-run restores every default.
    #1 sys_rst = 1'b1;
    for (int p = 0; p < 4; p++)
      expCfg[p] = eeprom_autoload_pkg::CFG_RESET;
    @(posedge clk);
    #1 sys_rst = 1'b0;
    checkAll();
    conclude();
  end

  // Cuts a hang short well beyond the some 160 cycles needed.
  initial
  begin
    #20000;
    error_cnt++;
    conclude();
  end
endmodule
